// [inc/flash_poll_pkg.sv]
// Constants, types and command words shared by the flash status poller and its bus cycle unit.
// Assumes a 16-bit parallel NOR flash with banked status reporting on its data pins.
package flash_poll_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DQ_W = 16;
  localparam int REG_AW = 8;
  localparam int CLK_MHZ = 250;

  // ----------------------------------------------------------------
  // Pin timing, in ns as given, then in whole clock cycles
  // ----------------------------------------------------------------
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_GAP_NS = 20;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Register map of the controller
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [REG_AW-1:0] ADDR_OFS = 8'h04;
  localparam logic [REG_AW-1:0] WDATA_OFS = 8'h08;
  localparam logic [REG_AW-1:0] STATUS_OFS = 8'h0C;
  localparam logic [REG_AW-1:0] RDATA_OFS = 8'h10;

  // STATUS register fields.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OK_BIT = 1;
  localparam int ST_TIMING_FAIL_BIT = 2;
  localparam int ST_ABORT_FAIL_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_NOT_ACCEPTED_BIT = 5;
  localparam int ST_SUSPENDED_BIT = 6;
  localparam int ST_POLL_TIMEOUT_BIT = 7;
  localparam int ST_LAST_STATUS_LSB = 8;

  // ----------------------------------------------------------------
  // Status bits on the flash data pins
  // ----------------------------------------------------------------
  localparam int POLLING_BIT = 7;
  localparam int BUSY_TOGGLE_BIT = 6;
  localparam int TIMING_LIMIT_FLAG = 5;
  localparam int ERASE_TIMER_FLAG = 3;
  localparam int SECTOR_ERASE_TOGGLE_BIT = 2;
  localparam int BUFFER_ABORT_FLAG = 1;

  // ----------------------------------------------------------------
  // Command words and unlock addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] UNLOCK_A1 = 12'h555;
  localparam logic [11:0] UNLOCK_A2 = 12'h2AA;
  localparam logic [DQ_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DQ_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DQ_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DQ_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DQ_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DQ_W-1:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [DQ_W-1:0] CMD_RESUME = 16'h0030;
  localparam logic [DQ_W-1:0] CMD_RESET = 16'h00F0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_ADD_SECTOR,
    OP_SUSPEND,
    OP_RESUME,
    OP_RESET,
    OP_ABORT_RESET,
    OP_POLL
  } op_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] data;
    logic last;
  } bus_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } flash_pins_s;

endpackage : flash_poll_pkg

// [rtl/flash_bus_cycle.sv]
// One asynchronous read or write cycle on the flash pins.
// Assumes start arrives only while idle; done pulses once in the last gap cycle after the strobes are back high.
`timescale 1ns/1ps
module flash_bus_cycle (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Request and answer
  input wire logic start,
  input wire logic is_write,
  input wire flash_poll_pkg::bus_req_s req,
  output logic done,
  output logic [flash_poll_pkg::DQ_W-1:0] rdata,
  // Flash pins
  input wire logic [flash_poll_pkg::DQ_W-1:0] dq_in,
  output flash_poll_pkg::flash_pins_s pins
);
  import flash_poll_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_GAP} cyc_e;

  cyc_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic [DQ_W-1:0] rdata_reg, rdata_next;
  flash_pins_s pins_reg, pins_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    rdata_next = rdata_reg;
    pins_next = pins_reg;
    case (state_reg)
      C_IDLE: begin
        if (start) begin
          pins_next.addr = req.addr;
          pins_next.dq_out = req.data;
          pins_next.dq_oe_n = ~is_write;
          pins_next.ce_n = 1'b0;
          wr_next = is_write;
          state_next = C_SETUP;
        end
      end
      C_SETUP: begin
        // Address settles for a cycle before the strobe falls.
        if (wr_reg) begin
          pins_next.we_n = 1'b0;
          cnt_next = 8'(WP_CYC - 1);
        end else begin
          pins_next.oe_n = 1'b0;
          cnt_next = 8'(ACC_CYC - 1);
        end
        state_next = C_STROBE;
      end
      C_STROBE: begin
        if (cnt_reg == 8'h00) begin
          if (!wr_reg) begin
            rdata_next = dq_in;
          end
          // Both strobes go high, so the next read is a fresh cycle.
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          pins_next.ce_n = 1'b1;
          cnt_next = 8'(GAP_CYC - 1);
          state_next = C_GAP;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      C_GAP: begin
        // Write data is held through the first gap cycle, then released.
        pins_next.dq_oe_n = 1'b1;
        if (cnt_reg == 8'h00) begin
          state_next = C_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        state_next = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= C_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      pins_reg <= '{addr: '0, dq_out: '0, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      rdata_reg <= rdata_next;
      pins_reg <= pins_next;
    end
  end

  assign done = (state_reg == C_GAP) && (cnt_reg == 8'h00);
  assign rdata = rdata_reg;
  assign pins = pins_reg;

endmodule : flash_bus_cycle

// [rtl/flash_status_poller.sv]
// Host controller that issues program and erase sequences to a banked NOR flash and polls
// its status bits until the embedded operation ends, recovering on its own from timing and buffer-abort faults but not from a poll timeout.
// Assumes software drives the plain register port and that the flash sits on the pins.
//
// Function
// - Cycle a strobe between status reads.
// - Read status twice, compare, steady means done.
// - Timing flag set: recheck, toggling means fail.
// - Resumed polling restarts check from scratch.
// - Reset command after timing fault.
// - Check timer flag around added sector erase.
// - Buffer abort needs abort reset sequence.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module flash_status_poller #(
  parameter int MAX_POLLS = 1000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [flash_poll_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash pins
  input wire logic [flash_poll_pkg::DQ_W-1:0] flash_dq_in,
  output flash_poll_pkg::flash_pins_s flash_pins,
  output logic flash_reset_n
);
  import flash_poll_pkg::*;

  // ----------------------------------------------------------------
  // Command sequences
  // ----------------------------------------------------------------
  // Unlock cycles land in the bank of the target address, so the sequence is decoded by
  // that bank alone and other banks keep returning array data.
  function automatic bus_req_s seq_step(input op_e op, input logic [2:0] step,
                                        input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d);
    bus_req_s r;
    logic [ADDR_W-1:0] u1;
    logic [ADDR_W-1:0] u2;
    u1 = {a[ADDR_W-1:12], UNLOCK_A1};
    u2 = {a[ADDR_W-1:12], UNLOCK_A2};
    r = '{addr: a, data: CMD_RESET, last: 1'b1};
    case (op)
      OP_PROGRAM: begin
        case (step)
          3'd0: r = '{addr: u1, data: CMD_UNLOCK1, last: 1'b0};
          3'd1: r = '{addr: u2, data: CMD_UNLOCK2, last: 1'b0};
          3'd2: r = '{addr: u1, data: CMD_PROGRAM, last: 1'b0};
          default: r = '{addr: a, data: d, last: 1'b1};
        endcase
      end
      OP_SECTOR_ERASE: begin
        case (step)
          3'd0: r = '{addr: u1, data: CMD_UNLOCK1, last: 1'b0};
          3'd1: r = '{addr: u2, data: CMD_UNLOCK2, last: 1'b0};
          3'd2: r = '{addr: u1, data: CMD_ERASE_SETUP, last: 1'b0};
          3'd3: r = '{addr: u1, data: CMD_UNLOCK1, last: 1'b0};
          3'd4: r = '{addr: u2, data: CMD_UNLOCK2, last: 1'b0};
          default: r = '{addr: a, data: CMD_SECTOR_ERASE, last: 1'b1};
        endcase
      end
      OP_ABORT_RESET: begin
        case (step)
          3'd0: r = '{addr: u1, data: CMD_UNLOCK1, last: 1'b0};
          3'd1: r = '{addr: u2, data: CMD_UNLOCK2, last: 1'b0};
          default: r = '{addr: u1, data: CMD_RESET, last: 1'b1};
        endcase
      end
      OP_ADD_SECTOR: r = '{addr: a, data: CMD_SECTOR_ERASE, last: 1'b1};
      OP_SUSPEND: r = '{addr: a, data: CMD_SUSPEND, last: 1'b1};
      OP_RESUME: r = '{addr: a, data: CMD_RESUME, last: 1'b1};
      default: r = '{addr: a, data: CMD_RESET, last: 1'b1};
    endcase
    return r;
  endfunction : seq_step

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_PRE_CHECK, S_PRE_EVAL, S_POST_CHECK, S_POST_EVAL,
    S_POLL, S_POLL_EVAL, S_FINAL, S_FINAL_EVAL
  } st_e;

  st_e state_reg, state_next;
  st_e ret_reg, ret_next;
  op_e op_reg, op_next;
  logic [2:0] step_reg, step_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DQ_W-1:0] wdata_reg, wdata_next;
  logic [DQ_W-1:0] data_reg, data_next;
  logic [7:0] prev_reg, prev_next;
  logic have_prev_reg, have_prev_next;
  logic recheck_reg, recheck_next;
  logic recover_reg, recover_next;
  logic [15:0] polls_reg, polls_next;
  logic [7:0] flags_reg, flags_next;
  logic start_reg, start_next;
  logic write_reg, write_next;
  bus_req_s req_reg, req_next;
  logic [31:0] rdata_reg, rdata_next;
  logic reset_n_reg;

  logic cyc_done;
  logic [DQ_W-1:0] cyc_rdata;
  logic [7:0] cur;
  logic busy_toggled;
  logic erase_toggled;
  bus_req_s step_req;

  flash_bus_cycle u_cycle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(start_reg),
    .is_write(write_reg),
    .req(req_reg),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .dq_in(flash_dq_in),
    .pins(flash_pins)
  );

  assign cur = cyc_rdata[7:0];
  assign busy_toggled = prev_reg[BUSY_TOGGLE_BIT] ^ cur[BUSY_TOGGLE_BIT];
  assign erase_toggled = prev_reg[SECTOR_ERASE_TOGGLE_BIT] ^ cur[SECTOR_ERASE_TOGGLE_BIT];
  assign step_req = seq_step(op_reg, step_reg, addr_reg, wdata_reg);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    op_next = op_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    data_next = data_reg;
    prev_next = prev_reg;
    have_prev_next = have_prev_reg;
    recheck_next = recheck_reg;
    recover_next = recover_reg;
    polls_next = polls_reg;
    flags_next = flags_reg;
    start_next = 1'b0;
    write_next = write_reg;
    req_next = req_reg;
    rdata_next = 32'h0000_0000;

    if (reg_rd) begin
      case (reg_addr)
        CTRL_OFS: rdata_next = {28'h000_0000, op_reg};
        ADDR_OFS: rdata_next = {8'h00, addr_reg};
        WDATA_OFS: rdata_next = {16'h0000, wdata_reg};
        STATUS_OFS: rdata_next = {16'h0000, prev_reg, flags_reg};
        RDATA_OFS: rdata_next = {16'h0000, data_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (reg_wr && state_reg == S_IDLE) begin
      if (reg_addr == ADDR_OFS) begin
        addr_next = reg_wdata[ADDR_W-1:0];
      end
      if (reg_addr == WDATA_OFS) begin
        wdata_next = reg_wdata[DQ_W-1:0];
      end
    end

    case (state_reg)
      S_IDLE: begin
        if (reg_wr && reg_addr == CTRL_OFS) begin
          flags_next = 8'h00;
          if (reg_wdata[3:0] > 4'(OP_POLL)) begin
            flags_next[ST_REFUSED_BIT] = 1'b1;
          end else begin
            op_next = op_e'(reg_wdata[3:0]);
            flags_next[ST_BUSY_BIT] = 1'b1;
            step_next = 3'd0;
            recover_next = 1'b0;
            // Polling always starts over, never resumes a half-done comparison.
            have_prev_next = 1'b0;
            recheck_next = 1'b0;
            polls_next = 16'h0000;
            case (op_e'(reg_wdata[3:0]))
              OP_READ: state_next = S_FINAL;
              OP_POLL: state_next = S_POLL;
              OP_ADD_SECTOR: state_next = S_PRE_CHECK;
              default: state_next = S_ISSUE;
            endcase
          end
        end else if (reg_wr && state_reg != S_IDLE) begin
          flags_next[ST_REFUSED_BIT] = 1'b1;
        end
      end
      S_ISSUE: begin
        start_next = 1'b1;
        write_next = 1'b1;
        req_next = step_req;
        step_next = step_reg + 3'd1;
        state_next = S_WAIT;
        if (!step_req.last) begin
          ret_next = S_ISSUE;
        end else if (recover_reg) begin
          ret_next = S_IDLE;
        end else begin
          case (op_reg)
            // Program and suspend finish only when the toggle bit goes steady.
            OP_PROGRAM, OP_SUSPEND: ret_next = S_POLL;
            OP_ADD_SECTOR: ret_next = S_POST_CHECK;
            default: ret_next = S_IDLE;
          endcase
        end
      end
      S_WAIT: begin
        if (cyc_done) begin
          state_next = ret_reg;
          if (ret_reg == S_IDLE) begin
            flags_next[ST_BUSY_BIT] = 1'b0;
            flags_next[ST_OK_BIT] = ~recover_reg;
          end
        end
      end
      S_PRE_CHECK, S_POST_CHECK, S_POLL, S_FINAL: begin
        start_next = 1'b1;
        write_next = 1'b0;
        // Status reads stay in the target's bank, which is the one running the operation.
        req_next = '{addr: addr_reg, data: wdata_reg, last: 1'b1};
        case (state_reg)
          S_PRE_CHECK: ret_next = S_PRE_EVAL;
          S_POST_CHECK: ret_next = S_POST_EVAL;
          S_POLL: ret_next = S_POLL_EVAL;
          default: ret_next = S_FINAL_EVAL;
        endcase
        state_next = S_WAIT;
      end
      S_PRE_EVAL: begin
        prev_next = cur;
        if (cur[ERASE_TIMER_FLAG]) begin
          // Erase already began; an added sector would be ignored, so it is not sent.
          flags_next[ST_REFUSED_BIT] = 1'b1;
          flags_next[ST_BUSY_BIT] = 1'b0;
          state_next = S_IDLE;
        end else begin
          state_next = S_ISSUE;
        end
      end
      S_POST_EVAL: begin
        prev_next = cur;
        // A high timer flag here means the added sector may have come too late.
        flags_next[ST_NOT_ACCEPTED_BIT] = cur[ERASE_TIMER_FLAG];
        flags_next[ST_OK_BIT] = ~cur[ERASE_TIMER_FLAG];
        flags_next[ST_BUSY_BIT] = 1'b0;
        state_next = S_IDLE;
      end
      S_POLL_EVAL: begin
        prev_next = cur;
        polls_next = polls_reg + 16'h0001;
        state_next = S_POLL;
        if (!have_prev_reg) begin
          have_prev_next = 1'b1;
        end else if (!busy_toggled) begin
          // Steady toggle bit: finished, or erase suspended when the sector bit still toggles.
          flags_next[ST_SUSPENDED_BIT] = erase_toggled;
          state_next = (op_reg == OP_SUSPEND) ? S_IDLE : S_FINAL;
          if (op_reg == OP_SUSPEND) begin
            flags_next[ST_BUSY_BIT] = 1'b0;
            flags_next[ST_OK_BIT] = 1'b1;
          end
        end else if (recheck_reg && cur[BUFFER_ABORT_FLAG]) begin
          // A plain reset does not clear an aborted buffer load.
          flags_next[ST_ABORT_FAIL_BIT] = 1'b1;
          op_next = OP_ABORT_RESET;
          recover_next = 1'b1;
          step_next = 3'd0;
          state_next = S_ISSUE;
        end else if (recheck_reg) begin
          flags_next[ST_TIMING_FAIL_BIT] = 1'b1;
          op_next = OP_RESET;
          recover_next = 1'b1;
          step_next = 3'd0;
          state_next = S_ISSUE;
        end else if (cur[TIMING_LIMIT_FLAG] || cur[BUFFER_ABORT_FLAG]) begin
          recheck_next = 1'b1;
        end else if (polls_reg == 16'(MAX_POLLS - 1)) begin
          // Giving up leaves the flash busy; a later poll command starts from the beginning.
          flags_next[ST_POLL_TIMEOUT_BIT] = 1'b1;
          flags_next[ST_BUSY_BIT] = 1'b0;
          state_next = S_IDLE;
        end
      end
      S_FINAL_EVAL: begin
        // The read after a steady toggle bit carries array data, not status.
        data_next = cyc_rdata;
        flags_next[ST_BUSY_BIT] = 1'b0;
        flags_next[ST_OK_BIT] = 1'b1;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      op_reg <= OP_READ;
      step_reg <= 3'd0;
      addr_reg <= '0;
      wdata_reg <= 16'h0000;
      data_reg <= 16'h0000;
      prev_reg <= 8'h00;
      have_prev_reg <= 1'b0;
      recheck_reg <= 1'b0;
      recover_reg <= 1'b0;
      polls_reg <= 16'h0000;
      flags_reg <= 8'h00;
      start_reg <= 1'b0;
      write_reg <= 1'b0;
      req_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      reset_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      op_reg <= op_next;
      step_reg <= step_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      data_reg <= data_next;
      prev_reg <= prev_next;
      have_prev_reg <= have_prev_next;
      recheck_reg <= recheck_next;
      recover_reg <= recover_next;
      polls_reg <= polls_next;
      flags_reg <= flags_next;
      start_reg <= start_next;
      write_reg <= write_next;
      req_reg <= req_next;
      rdata_reg <= rdata_next;
      reset_n_reg <= 1'b1;
    end
  end

  assign reg_rdata = rdata_reg;
  // The flash is held in hardware reset while the controller is, ending any operation.
  assign flash_reset_n = reset_n_reg;

endmodule : flash_status_poller

// [verif/flash_status_poller_asserts.sv]
// Checker for the flash status poller, bound to the top module's ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module flash_status_poller_asserts #(
  parameter int MAX_POLLS = 1000
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [flash_poll_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [flash_poll_pkg::DQ_W-1:0] flash_dq_in,
  input wire flash_poll_pkg::flash_pins_s flash_pins,
  input wire logic flash_reset_n
);
  import flash_poll_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_GAP: assert property ($rose(flash_pins.oe_n) |-> (flash_pins.oe_n && flash_pins.ce_n)[*5])
    else $error("strobes not released for the gap");
  AST_SEL: assert property ((!flash_pins.oe_n || !flash_pins.we_n) |-> !flash_pins.ce_n)
    else $error("strobe without chip select");
  AST_CLASH: assert property (!flash_pins.dq_oe_n |-> flash_pins.oe_n)
    else $error("data driven during a read");
  AST_RD_LEN: assert property ($fell(flash_pins.oe_n) |-> !flash_pins.oe_n[*8])
    else $error("read strobe too short");
  AST_WE_LEN: assert property ($fell(flash_pins.we_n) |-> !flash_pins.we_n[*8] ##1 !flash_pins.we_n ##1 flash_pins.we_n)
    else $error("write strobe not nine cycles");
  AST_UNLOCK: assert property (($fell(flash_pins.we_n) && flash_pins.dq_out == CMD_UNLOCK1) |-> flash_pins.addr[11:0] == UNLOCK_A1)
    else $error("unlock word at wrong address");
  AST_HWRST: assert property (flash_reset_n |=> flash_reset_n)
    else $error("hardware reset used for recovery");
  AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  cover property ($rose(flash_pins.oe_n));
  cover property ($rose(flash_pins.we_n));
  cover property (reg_rd ##1 reg_rdata != 32'h0000_0000);
endmodule : flash_status_poller_asserts

// [verif/flash_dev_model.sv]
// Behavioural banked NOR flash that reports write status on its data pins.
// Assumes the controller raises its strobes together at the end of each cycle.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int BUSY_READS = 8
) (
  input wire flash_poll_pkg::flash_pins_s pins,
  input wire logic flash_reset_n,
  // Scenario: 0 clean, 1 pulse-limit overrun, 2 buffer abort, 3 never ends.
  input wire logic [1:0] fault,
  output logic [15:0] dq
);
  import flash_poll_pkg::*;
  logic [15:0] h1, h2, h3, word;
  logic [15:0] pdata = 16'hFFFF;
  logic [15:0] held = 16'h0000;
  logic [23:0] paddr = 24'h000000;
  logic busy = 1'b0, erase = 1'b0, susp = 1'b0, tog = 1'b0, tog2 = 1'b0;
  int left, age;
  always_comb begin
    word = (pins.addr == paddr) ? pdata : 16'hFFFF;
    if (busy && pins.addr[23:22] == paddr[23:22]) begin
      word = {8'h00, erase ? susp : ~pdata[7], tog, fault == 2'h1, 1'b0,
              erase && age > 1, tog2, fault == 2'h2, 1'b0};
    end
  end
  // A released bus shows the inverse of the last word so a stale copy never passes.
  assign dq = (pins.ce_n || pins.oe_n) ? ~held : word;
  always @(posedge pins.oe_n) begin
    held = word;
    if (busy && pins.addr[23:22] == paddr[23:22]) begin
      age = age + 1;
      tog2 = tog2 ^ erase;
      if (!susp) begin
        tog = ~tog;
        left = left - (fault == 2'h0);
      end
      busy = left > 0;
    end
  end
  always @(posedge pins.we_n or negedge flash_reset_n) begin
    if (!flash_reset_n || pins.dq_out == CMD_RESET) begin
      busy = 1'b0;
      susp = 1'b0;
    end else if ({h3, h2, h1} == {CMD_UNLOCK1, CMD_UNLOCK2, CMD_PROGRAM}) begin
      paddr = pins.addr;
      pdata = (pins.addr[21:20] == 2'b11) ? 16'hFFFF : pins.dq_out;
      erase = 1'b0;
      busy = 1'b1;
      left = BUSY_READS;
    end else if (pins.dq_out == CMD_SECTOR_ERASE && h1 == CMD_UNLOCK2 && h3 == CMD_ERASE_SETUP) begin
      paddr = pins.addr;
      pdata = 16'hFFFF;
      erase = 1'b1;
      busy = 1'b1;
      left = BUSY_READS;
      age = 0;
    end else if (pins.dq_out == CMD_RESUME && susp) begin
      susp = 1'b0;
    end else if (pins.dq_out == CMD_SECTOR_ERASE && busy && erase && age < 2) begin
      age = 0;
    end else if (pins.dq_out == CMD_SUSPEND && busy && erase) begin
      susp = 1'b1;
    end
    h3 = h2;
    h2 = h1;
    h1 = pins.dq_out;
  end
endmodule : flash_dev_model

// [verif/flash_status_poller_tb.sv]
// Self-checking bench for the flash status poller against the flash model.
// Assumes the package register map; MAX_POLLS is cut to 16 for a short run.
`timescale 1ns/1ps
module flash_status_poller_tb;
  import flash_poll_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [REG_AW-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, got;
  logic [DQ_W-1:0] flash_dq_in;
  flash_pins_s flash_pins;
  logic flash_reset_n;
  logic [1:0] fault = 2'h0;
  int n_fail = 0;
  int checks_done = 0;
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  flash_status_poller #(.MAX_POLLS(16)) flash_status_poller_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_dq_in(flash_dq_in),
    .flash_pins(flash_pins), .flash_reset_n(flash_reset_n));
  flash_dev_model #(.BUSY_READS(12)) flash_dev_model_i (.pins(flash_pins),
    .flash_reset_n(flash_reset_n), .fault(fault), .dq(flash_dq_in));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Runs one operation and polls until busy clears; the caller sees the last status.
  task automatic run(input logic [3:0] op, input logic [23:0] a, input logic [15:0] d);
    wr(ADDR_OFS, {8'h00, a});
    wr(WDATA_OFS, {16'h0000, d});
    wr(CTRL_OFS, {28'h0000000, op});
    got = 32'h0000_0001;
    for (int i = 0; i < 4000 && got[ST_BUSY_BIT] !== 1'b0; i++) rd(STATUS_OFS);
    chk({31'h0, got[ST_BUSY_BIT]}, 32'h0);
  endtask : run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(CTRL_OFS, 32'h0000_000F);
    rd(STATUS_OFS);
    chk(got & 32'hFF, 32'h10);
    rd(8'h20);
    chk(got, 32'h0000_0000);
    $display("test registers done");
    run(4'h1, 24'h012345, 16'h1234);
    chk(got & 32'hFF, 32'h02);
    rd(RDATA_OFS);
    chk(got, 32'h1234);
    run(4'h1, 24'h312345, 16'h1234);
    rd(RDATA_OFS);
    chk(got, 32'hFFFF);
    fault <= 2'h1;
    run(4'h1, 24'h012346, 16'h00F1);
    chk(got & 32'hFF, 32'h04);
    chk({31'h0, flash_dev_model_i.busy}, 32'h0);
    fault <= 2'h2;
    run(4'h1, 24'h012346, 16'h00F2);
    chk(got & 32'hFF, 32'h08);
    chk({31'h0, flash_dev_model_i.busy}, 32'h0);
    fault <= 2'h3;
    run(4'h1, 24'h012347, 16'h0055);
    chk(got & 32'hFF, 32'h80);
    run(4'h6, 24'h012347, 16'h0000);
    chk({31'h0, flash_dev_model_i.busy}, 32'h0);
    fault <= 2'h0;
    $display("test program done");
    run(4'h2, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h02);
    run(4'h0, 24'hC00000, 16'h0000);
    rd(RDATA_OFS);
    chk(got, 32'hFFFF);
    run(4'h3, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h02);
    run(4'h3, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h20);
    run(4'h3, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h10);
    run(4'h4, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h42);
    run(4'h5, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h02);
    run(4'h8, 24'h400000, 16'h0000);
    chk(got & 32'hFF, 32'h02);
    rd(RDATA_OFS);
    chk(got, 32'hFFFF);
    $display("test erase done");
    report_and_stop();
  end
endmodule : flash_status_poller_tb
bind flash_status_poller flash_status_poller_asserts #(.MAX_POLLS(MAX_POLLS))
  flash_status_poller_asserts_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_dq_in(flash_dq_in), .flash_pins(flash_pins),
  .flash_reset_n(flash_reset_n));
